// file: design/gpio_mux_pkg.sv
// Package with register map, field layout, function codes and carrier types for the pin mux.
//
// Contract
// - Pin control precedence: pull enables, then global tristate, then function select.
// - pin_tristate_all bit 13 floats all audio and general pins; resets to 0.
// - Any set pull enable overrides every other function choice for that pin.
// - After reset pull-downs read 1 and pull-ups read 0 on the three pins.
// - Function select acts only with both pulls clear and tristate clear.
// - Codes 0000 input, 0001 divided clock, 0010 low, 0011 high.
// - Codes 0100 PLL lock, 0101 temperature OK, 0110 readback data, 0111 interrupt.
// - Codes 1000 mic detect, 1001 mic short detect; 1010 to 1111 reserved.
// - De-bounce enable 1 de-bounces input, needing timeout clock; 0 passes straight.
// - Each of five inputs has an interrupt enable, reset 0, unmasking its event.
// - Input-only pins act as digital inputs only while their enable is 1.
// - Polarity field inverts inputs: bits 7,6,4,3,2 for pins 8,7,5,4,3; resets 00h.
// - Input-only pins have only the input function, no outputs or pulls.
// - First control register: pin four in 15:8, pin three in 7:0.
// - Pin five fields in 7:0; input-only enables at bits 7,6,4 and 3,2,0.
// - Latched pin input state is readable at any time.
package gpio_mux_pkg;

  // ------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_TRISTATE = 6'h09;
  localparam logic [5:0] IDX_PIN34 = 6'h14;
  localparam logic [5:0] IDX_PIN5 = 6'h15;
  localparam logic [5:0] IDX_AUX = 6'h16;
  localparam logic [5:0] IDX_POLARITY = 6'h17;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h18;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h19;
  localparam logic [5:0] IDX_PIN_STATE = 6'h1A;

  // ------------------------------------------------------------
  // Reset values and writable bits.
  // ------------------------------------------------------------
  localparam logic [15:0] RST_TRISTATE = 16'h0000;
  localparam logic [15:0] RST_PIN34 = 16'h1010;
  localparam logic [15:0] RST_PIN5 = 16'h0010;
  localparam logic [15:0] RST_AUX = 16'h0000;
  localparam logic [15:0] RST_POLARITY = 16'h0000;
  localparam logic [15:0] WMASK_TRISTATE = 16'h2000;
  localparam logic [15:0] WMASK_PIN34 = 16'hFFFF;
  localparam logic [15:0] WMASK_PIN5 = 16'h00FF;
  localparam logic [15:0] WMASK_AUX = 16'h00DD;
  localparam logic [15:0] WMASK_POLARITY = 16'h00DC;

  // ------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------
  localparam int TRISTATE_BIT = 13;
  localparam int PIN_FOUR_LSB = 8;
  localparam int PIN_THREE_LSB = 0;
  localparam int PIN_FIVE_LSB = 0;
  localparam int AUX_EIGHT_LSB = 4;
  localparam int AUX_SEVEN_LSB = 0;
  localparam int POL_PIN_THREE = 2;
  localparam int POL_PIN_FOUR = 3;
  localparam int POL_PIN_FIVE = 4;
  localparam int POL_PIN_SEVEN = 6;
  localparam int POL_PIN_EIGHT = 7;

  // ------------------------------------------------------------
  // Timing: timeout clock periods an input must hold still.
  // ------------------------------------------------------------
  localparam logic [2:0] DEB_TICKS = 3'h4;

  // ------------------------------------------------------------
  // Types.
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_INPUT = 4'b0000,
    FN_CLOCK = 4'b0001,
    FN_LOW = 4'b0010,
    FN_HIGH = 4'b0011,
    FN_PLL_LOCK = 4'b0100,
    FN_TEMP_OK = 4'b0101,
    FN_READBACK = 4'b0110,
    FN_IRQ = 4'b0111,
    FN_MIC_DET = 4'b1000,
    FN_MIC_SHORT = 4'b1001
  } pin_function_t;

  typedef struct packed {
    logic input_debounce_en;
    logic input_irq_en;
    logic pin_pullup_en;
    logic pin_pulldown_en;
    logic [3:0] pin_function_select;
  } pin_cfg_t;

  typedef struct packed {
    logic input_debounce_en;
    logic input_irq_en;
    logic aux_input_enable;
  } aux_cfg_t;

  typedef struct packed {
    logic clock_div;
    logic pll_lock;
    logic temp_ok;
    logic readback;
    logic mic_detect;
    logic mic_short;
  } int_src_t;

endpackage : gpio_mux_pkg

// file: design/multi_function_gpio_mux.sv
// Top module: APB registers, pin function mux, input polarity, de-bounce and interrupts.
`timescale 1ns/1ps
module multi_function_gpio_mux
  import gpio_mux_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal signal sources
  input wire int_src_t int_src,
  input wire logic timeout_clock_en,
  input wire logic timeout_tick,
  // Bidirectional general pins, index 0..2 = three, four, five
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pin_pullup,
  output logic [2:0] pin_pulldown,
  // Input-only pins, index 0 = seven, 1 = eight
  input wire logic [1:0] aux_in,
  // Audio interface float and interrupt
  output logic aif_tristate,
  output logic irq
);

  // ------------------------------------------------------------
  // Helper functions.
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] wmask);
    merge = (old & ~wmask) | (wd[15:0] & wmask);
  endfunction : merge

  // Returns {output enable, level} for a bidirectional pin.
  function automatic logic [1:0] drive(input pin_cfg_t cfg, input logic tris,
                                       input int_src_t s, input logic irq_lvl);
    logic [1:0] r;
    r = 2'b00;
    if (cfg.pin_pullup_en || cfg.pin_pulldown_en) begin
      r = 2'b00;
    end else if (tris) begin
      r = 2'b00;
    end else begin
      case (cfg.pin_function_select)
        FN_INPUT: r = 2'b00;
        FN_CLOCK: r = {1'b1, s.clock_div};
        FN_LOW: r = 2'b10;
        FN_HIGH: r = 2'b11;
        FN_PLL_LOCK: r = {1'b1, s.pll_lock};
        FN_TEMP_OK: r = {1'b1, s.temp_ok};
        FN_READBACK: r = {1'b1, s.readback};
        FN_IRQ: r = {1'b1, irq_lvl};
        FN_MIC_DET: r = {1'b1, s.mic_detect};
        FN_MIC_SHORT: r = {1'b1, s.mic_short};
        default: r = 2'b00;
      endcase
    end
    drive = r;
  endfunction : drive

  // ------------------------------------------------------------
  // Register state.
  // ------------------------------------------------------------
  logic [15:0] tristate_reg;
  logic [15:0] pin34_reg;
  logic [15:0] pin5_reg;
  logic [15:0] aux_reg;
  logic [15:0] polarity_reg;
  logic [4:0] irq_status_reg;
  logic [4:0] irq_mask_reg;
  logic [4:0] irq_status_next;
  logic [4:0] state_reg;
  logic [4:0] state_next;
  logic [4:0] event_hit;
  logic wr_en;
  logic rd_setup;
  pin_cfg_t cfg [3];
  aux_cfg_t acfg [2];
  logic [4:0] deb_en;
  logic [4:0] irq_en;
  logic [4:0] raw_lvl;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  assign cfg[0] = pin_cfg_t'(pin34_reg[PIN_THREE_LSB +: 8]);
  assign cfg[1] = pin_cfg_t'(pin34_reg[PIN_FOUR_LSB +: 8]);
  assign cfg[2] = pin_cfg_t'(pin5_reg[PIN_FIVE_LSB +: 8]);
  assign acfg[0] = aux_cfg_t'({aux_reg[AUX_SEVEN_LSB + 3], aux_reg[AUX_SEVEN_LSB + 2],
                               aux_reg[AUX_SEVEN_LSB]});
  assign acfg[1] = aux_cfg_t'({aux_reg[AUX_EIGHT_LSB + 3], aux_reg[AUX_EIGHT_LSB + 2],
                               aux_reg[AUX_EIGHT_LSB]});

  // ------------------------------------------------------------
  // APB handshake and read data.
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (hit(paddr, IDX_TRISTATE)) begin
        prdata <= {16'h0000, tristate_reg};
      end else if (hit(paddr, IDX_PIN34)) begin
        prdata <= {16'h0000, pin34_reg};
      end else if (hit(paddr, IDX_PIN5)) begin
        prdata <= {16'h0000, pin5_reg};
      end else if (hit(paddr, IDX_AUX)) begin
        prdata <= {16'h0000, aux_reg};
      end else if (hit(paddr, IDX_POLARITY)) begin
        prdata <= {16'h0000, polarity_reg};
      end else if (hit(paddr, IDX_IRQ_STATUS)) begin
        prdata <= {27'h0000000, irq_status_reg};
      end else if (hit(paddr, IDX_IRQ_MASK)) begin
        prdata <= {27'h0000000, irq_mask_reg};
      end else if (hit(paddr, IDX_PIN_STATE)) begin
        prdata <= {27'h0000000, state_reg};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers.
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tristate_reg <= RST_TRISTATE;
      pin34_reg <= RST_PIN34;
      pin5_reg <= RST_PIN5;
      aux_reg <= RST_AUX;
      polarity_reg <= RST_POLARITY;
      irq_mask_reg <= 5'h00;
    end else if (wr_en) begin
      if (hit(paddr, IDX_TRISTATE)) begin
        tristate_reg <= merge(tristate_reg, pwdata, WMASK_TRISTATE);
      end
      if (hit(paddr, IDX_PIN34)) begin
        pin34_reg <= merge(pin34_reg, pwdata, WMASK_PIN34);
      end
      if (hit(paddr, IDX_PIN5)) begin
        pin5_reg <= merge(pin5_reg, pwdata, WMASK_PIN5);
      end
      if (hit(paddr, IDX_AUX)) begin
        aux_reg <= merge(aux_reg, pwdata, WMASK_AUX);
      end
      if (hit(paddr, IDX_POLARITY)) begin
        polarity_reg <= merge(polarity_reg, pwdata, WMASK_POLARITY);
      end
      if (hit(paddr, IDX_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[4:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Input path: polarity, enable and de-bounce per pin.
  // ------------------------------------------------------------
  assign raw_lvl[0] = pin_in[0] ^ polarity_reg[POL_PIN_THREE];
  assign raw_lvl[1] = pin_in[1] ^ polarity_reg[POL_PIN_FOUR];
  assign raw_lvl[2] = pin_in[2] ^ polarity_reg[POL_PIN_FIVE];
  assign raw_lvl[3] = (aux_in[0] & acfg[0].aux_input_enable)
                      ^ polarity_reg[POL_PIN_SEVEN];
  assign raw_lvl[4] = (aux_in[1] & acfg[1].aux_input_enable) ^ polarity_reg[POL_PIN_EIGHT];
  assign deb_en = {acfg[1].input_debounce_en, acfg[0].input_debounce_en,
                   cfg[2].input_debounce_en, cfg[1].input_debounce_en,
                   cfg[0].input_debounce_en};
  assign irq_en = {acfg[1].input_irq_en, acfg[0].input_irq_en, cfg[2].input_irq_en,
                   cfg[1].input_irq_en, cfg[0].input_irq_en};

  for (genvar i = 0; i < 5; i++) begin : g_in
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    always_comb begin
      state_next[i] = state_reg[i];
      cnt_next = 3'h0;
      if (!deb_en[i]) begin
        state_next[i] = raw_lvl[i];
      end else if (raw_lvl[i] != state_reg[i]) begin
        cnt_next = cnt_reg;
        if (timeout_clock_en && timeout_tick) begin
          if (cnt_reg == DEB_TICKS - 3'h1) begin
            state_next[i] = raw_lvl[i];
          end else begin
            cnt_next = cnt_reg + 3'h1;
          end
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= 3'h0;
        state_reg[i] <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        state_reg[i] <= state_next[i];
      end
    end

    assign event_hit[i] = (state_next[i] != state_reg[i]) && irq_en[i];
  end

  // ------------------------------------------------------------
  // Interrupt status, mask and output.
  // ------------------------------------------------------------
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_en && hit(paddr, IDX_IRQ_STATUS)) begin
      irq_status_next = irq_status_reg & ~pwdata[4:0];
    end
    irq_status_next = irq_status_next | event_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 5'h00;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // Pin drive.
  // ------------------------------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_out
    logic [1:0] drv;
    assign drv = drive(cfg[p], tristate_reg[TRISTATE_BIT], int_src, irq);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_oe[p] <= 1'b0;
        pin_out[p] <= 1'b0;
        pin_pullup[p] <= 1'b0;
        pin_pulldown[p] <= 1'b1;
      end else begin
        pin_oe[p] <= drv[1];
        pin_out[p] <= drv[0];
        pin_pullup[p] <= cfg[p].pin_pullup_en;
        pin_pulldown[p] <= cfg[p].pin_pulldown_en;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aif_tristate <= 1'b0;
    end else begin
      aif_tristate <= tristate_reg[TRISTATE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  property p_pull_wins;
    @(posedge pclk) disable iff (!presetn)
    (cfg[0].pin_pullup_en || cfg[0].pin_pulldown_en) |=> !pin_oe[0];
  endproperty
  a_pull_wins: assert property (p_pull_wins) else $error("pull did not float pin");

  property p_tris_floats;
    @(posedge pclk) disable iff (!presetn)
    tristate_reg[TRISTATE_BIT] |=> (pin_oe == 3'b000) && aif_tristate;
  endproperty
  a_tris_floats: assert property (p_tris_floats) else $error("tristate ignored");

  property p_sel_low;
    @(posedge pclk) disable iff (!presetn)
    (pin34_reg[11:8] == FN_LOW && !pin34_reg[13] && !pin34_reg[12] && !tristate_reg[13])
      |=> pin_oe[1] && !pin_out[1];
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("logic low not driven");

  property p_sel_high;
    @(posedge pclk) disable iff (!presetn)
    (cfg[0] == pin_cfg_t'({4'h0, FN_HIGH}) && !tristate_reg[TRISTATE_BIT])
      |=> pin_oe[0] && pin_out[0];
  endproperty
  a_sel_high: assert property (p_sel_high) else $error("logic high not driven");

  property p_sel_lock;
    @(posedge pclk) disable iff (!presetn)
    (cfg[2] == pin_cfg_t'({4'h0, FN_PLL_LOCK}) && !tristate_reg[TRISTATE_BIT])
      |=> pin_oe[2] && (pin_out[2] == $past(int_src.pll_lock));
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("lock not routed");

  property p_sel_mic;
    @(posedge pclk) disable iff (!presetn)
    (cfg[0] == pin_cfg_t'({4'h0, FN_MIC_DET}) && !tristate_reg[TRISTATE_BIT])
      |=> pin_oe[0] && (pin_out[0] == $past(int_src.mic_detect));
  endproperty
  a_sel_mic: assert property (p_sel_mic) else $error("mic detect not routed");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (cfg[1].pin_function_select > 4'h9) |=> !pin_oe[1];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code drove pin");

  property p_no_debounce;
    @(posedge pclk) disable iff (!presetn)
    !deb_en[2] |=> state_reg[2] == ($past(pin_in[2]) ^ $past(polarity_reg[POL_PIN_FIVE]));
  endproperty
  a_no_debounce: assert property (p_no_debounce) else $error("bypass level wrong");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(irq_status_next) & $past(irq_mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

endmodule : multi_function_gpio_mux

// file: tb/pin_partner.sv
// Far-side model: buttons and detect lines on the pins, and the timeout clock tick.
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input wire logic pclk,
  // Pin drive from the device
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_pullup,
  input wire logic [2:0] pin_pulldown,
  // Button settings from the bench
  input wire logic [2:0] btn_drive,
  input wire logic [2:0] btn_level,
  input wire logic [1:0] aux_level,
  // Levels seen by the device
  output logic [2:0] pin_in,
  output logic [1:0] aux_in,
  output logic timeout_tick
);
  logic [1:0] tick_reg = 2'h0;
  logic float_reg = 1'b0;
  always_ff @(posedge pclk) begin
    tick_reg <= tick_reg + 2'h1;
    float_reg <= ~float_reg;
  end
  // A timeout clock period is four system clock cycles.
  assign timeout_tick = (tick_reg == 2'h3);
  // An undriven, unpulled pin wanders from cycle to cycle.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (btn_drive[i]) begin
        pin_in[i] = btn_level[i];
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else if (pin_pulldown[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_reg;
      end
    end
  end
  assign aux_in = aux_level;
endmodule : pin_partner

// file: tb/test_multi_function_gpio_mux.sv
// Self-checking testbench for the pin function mux over APB.
`timescale 1ns/1ps
module test_multi_function_gpio_mux;
  import gpio_mux_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic timeout_clock_en, timeout_tick, aif_tristate, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int_src_t int_src;
  logic [2:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, btn_drive, btn_level;
  logic [1:0] aux_in, aux_level;
  logic [3:0] code;
  int n_mismatch = 0;
  int checks = 0;

  multi_function_gpio_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .int_src(int_src),
    .timeout_clock_en(timeout_clock_en), .timeout_tick(timeout_tick), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .pin_pulldown(pin_pulldown), .aux_in(aux_in), .aif_tristate(aif_tristate), .irq(irq));

  pin_partner model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .btn_drive(btn_drive),
    .btn_level(btn_level), .aux_level(aux_level), .pin_in(pin_in), .aux_in(aux_in),
    .timeout_tick(timeout_tick));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task close_out;
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr_en, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [5:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  function automatic logic exp_out(input logic [3:0] c, input int_src_t s);
    case (c)
      4'h1: return s.clock_div;
      4'h3: return 1'b1;
      4'h4: return s.pll_lock;
      4'h5: return s.temp_ok;
      4'h6: return s.readback;
      4'h8: return s.mic_detect;
      4'h9: return s.mic_short;
      default: return 1'b0;
    endcase
  endfunction : exp_out

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_src = int_src_t'(6'h00);
    timeout_clock_en = 1'b1;
    btn_drive = 3'h7;
    btn_level = 3'h0;
    aux_level = 2'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk({26'h0, pin_pulldown, pin_pullup}, 32'h38);
    rdc(IDX_TRISTATE, 32'h0);
    rdc(IDX_PIN34, 32'h1010);
    rdc(IDX_PIN5, 32'h10);
    rdc(IDX_AUX, 32'h0);
    rdc(IDX_POLARITY, 32'h0);
    apb(1'b0, 6'h30, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    wr(IDX_TRISTATE, 32'hFFFF);
    rdc(IDX_TRISTATE, 32'h2000);
    wr(IDX_POLARITY, 32'hFFFF);
    rdc(IDX_POLARITY, 32'hDC);
    wr(IDX_AUX, 32'hFFFF);
    rdc(IDX_AUX, 32'hDD);
    wr(IDX_TRISTATE, 32'h0);
    wr(IDX_POLARITY, 32'h0);
    wr(IDX_AUX, 32'h0);
    for (int k = 0; k < 20; k++) begin
      code = 4'(k % 10);
      wr(IDX_PIN34, {20'h0, code, 4'h0, code});
      wr(IDX_PIN5, {28'h0, code});
      int_src <= int_src_t'((k < 10) ? 6'h2A : 6'h15);
      settle(2);
      chk({29'h0, pin_oe}, (code == 4'h0) ? 32'h0 : 32'h7);
      chk({29'h0, pin_out & pin_oe}, {29'h0, {3{exp_out(code, int_src)}}});
    end
    wr(IDX_PIN34, 32'h0B0A);
    wr(IDX_PIN5, 32'h0F);
    settle(2);
    chk({29'h0, pin_oe}, 32'h0);
    wr(IDX_PIN34, 32'h0323);
    wr(IDX_PIN5, 32'h03);
    settle(2);
    chk({26'h0, pin_pullup, pin_oe}, 32'h0E);
    wr(IDX_TRISTATE, 32'h2000);
    settle(2);
    chk({25'h0, aif_tristate, pin_pullup, pin_oe}, 32'h48);
    wr(IDX_TRISTATE, 32'h0);
    wr(IDX_PIN34, 32'h0040);
    wr(IDX_PIN5, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1F);
    settle(3);
    wr(IDX_IRQ_STATUS, 32'h1F);
    rdc(IDX_IRQ_STATUS, 32'h0);
    btn_level <= 3'h3;
    settle(3);
    rdc(IDX_PIN_STATE, 32'h03);
    rdc(IDX_IRQ_STATUS, 32'h01);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 32'h01);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h0);
    btn_level <= 3'h2;
    settle(3);
    rdc(IDX_IRQ_STATUS, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1F);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 32'h01);
    wr(IDX_POLARITY, 32'h04);
    settle(2);
    rdc(IDX_PIN_STATE, 32'h03);
    wr(IDX_POLARITY, 32'h0);
    wr(IDX_PIN34, 32'h8040);
    btn_level <= 3'h0;
    settle(3);
    rdc(IDX_PIN_STATE, 32'h02);
    settle(40);
    rdc(IDX_PIN_STATE, 32'h00);
    timeout_clock_en <= 1'b0;
    btn_level <= 3'h2;
    settle(40);
    rdc(IDX_PIN_STATE, 32'h00);
    btn_level <= 3'h0;
    timeout_clock_en <= 1'b1;
    aux_level <= 2'h1;
    settle(3);
    rdc(IDX_PIN_STATE, 32'h00);
    wr(IDX_AUX, 32'h11);
    settle(2);
    rdc(IDX_PIN_STATE, 32'h08);
    wr(IDX_POLARITY, 32'hC0);
    settle(2);
    rdc(IDX_PIN_STATE, 32'h10);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk({26'h0, pin_pulldown, pin_pullup}, 32'h38);
    rdc(IDX_POLARITY, 32'h0);
    close_out();
  end
endmodule : test_multi_function_gpio_mux
